// ### rtl/pfb_branch_unit.sv
// Summary of operation
// - Conditional relative jump adds sign-extended displacement
// - Displacement adds to next-instruction address
// - Selector 0-3 picks zero carry overflow negative
// - Selector 4-7 picks transceiver status bits
// - Condition aliases are fixed flag/state relative jumps
// - Long conditional jump tests register bit position
// - Unconditional long jump takes all four addressing modes; relative jump takes immediate and register only
// - Conditional jumps: immediate relative, absolute long
// - Table jump rotates, masks copy, adds signed
// - Table jump displacement bit zero forced low
// - Relative call and absolute call provided
// - Call pushes pc, enable, flags, bank
// - Twelve-entry stack shared with interrupts
`include "pfb_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module pfb_branch_unit (
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst,
  // Decoded operation from the instruction decoder
  input  wire logic           opValid,
  input  wire pfb_pkg::pfb_op_t   opKind,
  input  wire pfb_pkg::pfb_mode_t opMode,
  input  wire logic [2:0]     flagSel,
  input  wire logic           wantState,
  input  wire logic [7:0]     dispImm,
  input  wire logic [15:0]    targetAbs,
  input  wire logic [15:0]    indexAddr,
  input  wire logic [7:0]     srcReg,
  input  wire logic [2:0]     bitPos,
  input  wire logic [2:0]     rotCount,
  input  wire logic [2:0]     maskCount,
  input  wire logic [15:0]    nextPc,
  // Flag sources
  input  wire logic           zeroFlag,
  input  wire logic           carryFlag,
  input  wire logic           overflowFlag,
  input  wire logic           negativeFlag,
  input  wire logic           receiverActiveFlag,
  input  wire logic           receiverErrorFlag,
  input  wire logic           rxDataAvailableFlag,
  input  wire logic           txQueueFullFlag,
  input  wire logic           globalInterruptEnable,
  input  wire logic [3:0]     bankSel,
  // Shared stack access from interrupt and return logic
  input  wire logic           intPush,
  input  wire logic [15:0]    intPc,
  input  wire logic           stackPop,
  output logic                popValid,
  output logic [15:0]         popPc,
  output logic [3:0]          popFlags,
  output logic                popIntEnable,
  output logic [3:0]          popBank,
  // Program counter redirect
  output logic                pcLoad,
  output logic [15:0]         pcTarget,
  output logic                flushFetch,
  // Register port
  input  wire logic [3:0]     regAddr,
  input  wire logic [7:0]     regWdata,
  input  wire logic           regWr,
  input  wire logic           regRd,
  output logic [7:0]          regRdata
);

  // Stack storage and occupancy
  logic [`PFB_ENTRY_W-1:0] stackMem [0:`PFB_STACK_DEPTH-1];
  logic [3:0]  depth;            // Entries in use
  logic        stackFull;        // No room left
  logic        stackEmpty;       // Nothing to pop
  // Software state
  logic [7:0]  ctrl;             // Control register
  logic        ovfSticky;        // Push refused or lost
  logic        unfSticky;        // Pop on empty stack
  // Decode results
  logic        flagBit;          // Selected condition flag
  logic        isCall;           // Operation is a call
  logic        illegalMode;      // Mode not allowed for this form
  logic        wantTake;         // Condition met before stack check
  logic        taken;            // Branch is actually taken
  logic [15:0] next_target;      // Computed destination
  logic [7:0]  tableDisp;        // Rotated and masked displacement
  logic        callPush;         // A call writes the stack
  logic        anyPush;          // Call or interrupt writes
  logic        doPush;           // Push that fits or, guard off, overwrites the top
  logic        doPop;            // Pop that has data
  logic        sclrPulse;        // Software stack clear
  logic [`PFB_ENTRY_W-1:0] pushEntry;

  assign stackFull  = (depth == 4'(`PFB_STACK_DEPTH));
  assign stackEmpty = (depth == 4'h0);
  assign sclrPulse  = regWr && (regAddr == `PFB_ADDR_CTRL) && regWdata[`PFB_CTRL_SCLR];

  // Flag select: ALU condition flags in the low half, transceiver bits above
  always_comb begin
    unique case (flagSel)
      3'h0:    flagBit = zeroFlag;
      3'h1:    flagBit = carryFlag;
      3'h2:    flagBit = overflowFlag;
      3'h3:    flagBit = negativeFlag;
      3'h4:    flagBit = receiverActiveFlag;
      3'h5:    flagBit = receiverErrorFlag;
      3'h6:    flagBit = rxDataAvailableFlag;
      3'h7:    flagBit = txQueueFullFlag;
    endcase
  end

  // Table jump: rotate a copy right, keep low bits, clear bit zero
  // The source register itself is never written here
  always_comb begin
    logic [15:0] dbl;
    dbl       = {srcReg, srcReg} >> rotCount;
    tableDisp = dbl[7:0] & (8'hFF >> maskCount) & 8'hFE;
  end

  // Destination and condition for each operation
  // Aliases arrive already as flag selector plus wanted state
  always_comb begin
    next_target = nextPc;
    wantTake    = 1'b0;
    illegalMode = 1'b0;
    isCall      = 1'b0;
    unique case (opKind)
      pfb_pkg::PFB_OP_REL_JUMP: begin
        wantTake    = 1'b1;
        illegalMode = !(opMode == pfb_pkg::PFB_AM_IMM || opMode == pfb_pkg::PFB_AM_REG);
        if (opMode == pfb_pkg::PFB_AM_REG) begin
          next_target = nextPc + {{8{srcReg[7]}}, srcReg};
        end else begin
          next_target = nextPc + {{8{dispImm[7]}}, dispImm};
        end
      end
      pfb_pkg::PFB_OP_COND_REL: begin
        wantTake    = (flagBit == wantState);
        illegalMode = (opMode != pfb_pkg::PFB_AM_IMM);
        next_target = nextPc + {{8{dispImm[7]}}, dispImm};
      end
      pfb_pkg::PFB_OP_LONG_JUMP: begin
        wantTake = 1'b1;
        unique case (opMode)
          pfb_pkg::PFB_AM_IMM: next_target = {8'h00, dispImm};
          pfb_pkg::PFB_AM_REG: next_target = {8'h00, srcReg};
          pfb_pkg::PFB_AM_ABS: next_target = targetAbs;
          pfb_pkg::PFB_AM_IDX: next_target = indexAddr;
          default:             illegalMode = 1'b1;
        endcase
      end
      pfb_pkg::PFB_OP_COND_LONG: begin
        wantTake    = (srcReg[bitPos] == wantState);
        illegalMode = (opMode != pfb_pkg::PFB_AM_ABS);
        next_target = targetAbs;
      end
      pfb_pkg::PFB_OP_ROT_MASK: begin
        wantTake    = 1'b1;
        next_target = nextPc + {{8{tableDisp[7]}}, tableDisp};
      end
      pfb_pkg::PFB_OP_CALL_REL: begin
        wantTake    = 1'b1;
        isCall      = 1'b1;
        next_target = nextPc + {{8{dispImm[7]}}, dispImm};
      end
      pfb_pkg::PFB_OP_CALL_LONG: begin
        wantTake    = 1'b1;
        isCall      = 1'b1;
        next_target = targetAbs;
      end
      default: illegalMode = 1'b1;  // Non one-hot code does nothing
    endcase
  end

  // A call that cannot be stacked under the guard is not taken,
  // so the return address is never silently lost; a pop in the
  // same cycle frees the top slot, so that call still goes
  assign callPush = opValid && isCall && !illegalMode;
  assign taken    = opValid && wantTake && !illegalMode &&
                    !(isCall && stackFull && ctrl[`PFB_CTRL_GUARD] && !doPop);
  assign anyPush  = (callPush || intPush) && !sclrPulse;
  assign doPop    = stackPop && !stackEmpty && !sclrPulse;
  // Without the guard a full stack overwrites its top entry
  assign doPush   = anyPush && (!stackFull || !ctrl[`PFB_CTRL_GUARD] || doPop);

  // Entry contents; a call wins over an interrupt in the same cycle
  assign pushEntry = callPush ?
    {bankSel, globalInterruptEnable, negativeFlag, overflowFlag,
     carryFlag, zeroFlag, nextPc} :
    {bankSel, globalInterruptEnable, negativeFlag, overflowFlag,
     carryFlag, zeroFlag, intPc};

  // Redirect pulse to the fetch unit and its destination
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pcLoad     <= 1'b0;
      flushFetch <= 1'b0;
      pcTarget   <= 16'h0000;
    end else begin
      pcLoad     <= taken;
      flushFetch <= taken;
      if (taken) begin
        pcTarget <= next_target;
      end
    end
  end

  // Stack occupancy: twelve entries, calls and interrupts share them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      depth <= 4'h0;
    end else if (sclrPulse) begin
      depth <= 4'h0;
    end else if (doPush && !doPop && !stackFull) begin
      depth <= depth + 4'h1;
    end else if (doPop && !doPush) begin
      depth <= depth - 4'h1;
    end
  end

  // Stack storage; push with pop replaces the top in place
  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      if (doPop || stackFull) begin
        stackMem[depth - 4'h1] <= pushEntry;
      end else begin
        stackMem[depth] <= pushEntry;
      end
    end
  end

  // Popped entry, valid for one cycle after the pop request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      popValid <= 1'b0;
      popPc    <= 16'h0000;
      popFlags <= 4'h0;
      popIntEnable <= 1'b0;
      popBank  <= 4'h0;
    end else begin
      popValid <= doPop;
      if (doPop) begin
        popPc    <= stackMem[depth - 4'h1][`PFB_ENT_PC];
        popFlags <= stackMem[depth - 4'h1][`PFB_ENT_FLAGS];
        popIntEnable <= stackMem[depth - 4'h1][`PFB_ENT_IEN];
        popBank  <= stackMem[depth - 4'h1][`PFB_ENT_BANK];
      end
    end
  end

  // Control register; the clear bit is a pulse and is not stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl <= `PFB_CTRL_RESET;
    end else if (regWr && regAddr == `PFB_ADDR_CTRL) begin
      ctrl <= {7'h00, regWdata[`PFB_CTRL_GUARD]};
    end
  end

  // Sticky stack errors; a new event beats a write-one clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovfSticky <= 1'b0;
      unfSticky <= 1'b0;
    end else begin
      if (anyPush && stackFull && !doPop) begin
        ovfSticky <= 1'b1;
      end else if (regWr && regAddr == `PFB_ADDR_STATUS && regWdata[`PFB_ST_OVF]) begin
        ovfSticky <= 1'b0;
      end
      if (stackPop && stackEmpty) begin
        unfSticky <= 1'b1;
      end else if (regWr && regAddr == `PFB_ADDR_STATUS && regWdata[`PFB_ST_UNF]) begin
        unfSticky <= 1'b0;
      end
    end
  end

  // Read data one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `PFB_ADDR_CTRL:   regRdata <= ctrl;
        `PFB_ADDR_STATUS: regRdata <= {unfSticky, ovfSticky, stackEmpty, stackFull, depth};
        `PFB_ADDR_TGT_LO: regRdata <= pcTarget[7:0];
        `PFB_ADDR_TGT_HI: regRdata <= pcTarget[15:8];
        default:          regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Checks next to the logic they guard
  cond_rel_a: assert property (@(posedge ref_clk) disable iff (rst)
    opValid && opKind == pfb_pkg::PFB_OP_COND_REL && opMode == pfb_pkg::PFB_AM_IMM
    |=> pcLoad == ($past(flagBit) == $past(wantState)))
    else $error("conditional relative jump decision wrong");

  rel_base_a: assert property (@(posedge ref_clk) disable iff (rst)
    opValid && opKind == pfb_pkg::PFB_OP_REL_JUMP && opMode == pfb_pkg::PFB_AM_IMM
    |=> pcTarget == $past(nextPc) + {{8{$past(dispImm[7])}}, $past(dispImm)})
    else $error("relative target not next pc plus displacement");

  flag_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
    flagSel == 3'h1 |-> flagBit == carryFlag)
    else $error("carry flag not selected by code one");

  tsr_sel_a: assert property (@(posedge ref_clk) disable iff (rst)
    flagSel == 3'h6 |-> flagBit == rxDataAvailableFlag)
    else $error("data available not selected by code six");

  long_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    opValid && opKind == pfb_pkg::PFB_OP_COND_LONG && opMode == pfb_pkg::PFB_AM_ABS
    && srcReg[bitPos] == wantState |=> pcLoad && pcTarget == $past(targetAbs))
    else $error("long conditional jump not taken on bit match");

  cond_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
    opValid && opKind == pfb_pkg::PFB_OP_COND_REL && opMode != pfb_pkg::PFB_AM_IMM
    |=> !pcLoad)
    else $error("conditional relative jump accepted a non-immediate mode");

  table_lsb_a: assert property (@(posedge ref_clk) disable iff (rst)
    opValid && opKind == pfb_pkg::PFB_OP_ROT_MASK
    |=> pcLoad && (pcTarget[0] == $past(nextPc[0])))
    else $error("table jump displacement bit zero not clear");

  call_push_a: assert property (@(posedge ref_clk) disable iff (rst)
    opValid && opKind == pfb_pkg::PFB_OP_CALL_LONG && depth < 4'hB && !stackPop
    && !sclrPulse |=> depth == $past(depth) + 4'h1 ##1 1'b1)
    else $error("call did not push one entry");

  depth_max_a: assert property (@(posedge ref_clk) disable iff (rst)
    depth <= 4'(`PFB_STACK_DEPTH))
    else $error("stack depth beyond twelve");

  flush_a: assert property (@(posedge ref_clk) disable iff (rst)
    pcLoad == flushFetch)
    else $error("redirect without fetch discard");

endmodule : pfb_branch_unit

`default_nettype wire

// ### rtl/pfb_defines.svh
`ifndef PFB_DEFINES_SVH
`define PFB_DEFINES_SVH

// Register indices on the plain register port
`define PFB_ADDR_CTRL     4'h0
`define PFB_ADDR_STATUS   4'h1
`define PFB_ADDR_TGT_LO   4'h2
`define PFB_ADDR_TGT_HI   4'h3

// Control register fields and reset value
`define PFB_CTRL_GUARD    0
`define PFB_CTRL_SCLR     1
`define PFB_CTRL_RESET    8'h01

// Status register fields
`define PFB_ST_FULL       4
`define PFB_ST_EMPTY      5
`define PFB_ST_OVF        6
`define PFB_ST_UNF        7

// Return stack geometry
`define PFB_STACK_DEPTH   12
`define PFB_ENTRY_W       25

// Stack entry layout: {bank, int enable, n, v, c, z, pc}
`define PFB_ENT_PC        15:0
`define PFB_ENT_FLAGS     19:16
`define PFB_ENT_IEN       20
`define PFB_ENT_BANK      24:21

`endif

// ### rtl/pfb_pkg.sv
package pfb_pkg;

  // Decoded program-flow operation, one-hot
  typedef enum logic [6:0] {
    PFB_OP_REL_JUMP  = 7'h01,  // Unconditional relative jump
    PFB_OP_COND_REL  = 7'h02,  // Flag-tested relative jump
    PFB_OP_LONG_JUMP = 7'h04,  // Unconditional absolute jump
    PFB_OP_COND_LONG = 7'h08,  // Register-bit-tested absolute jump
    PFB_OP_ROT_MASK  = 7'h10,  // Rotate-and-mask table jump
    PFB_OP_CALL_REL  = 7'h20,  // Relative call
    PFB_OP_CALL_LONG = 7'h40   // Absolute call
  } pfb_op_t;

  // Operand addressing mode, one-hot
  typedef enum logic [3:0] {
    PFB_AM_IMM = 4'h1,
    PFB_AM_REG = 4'h2,
    PFB_AM_ABS = 4'h4,
    PFB_AM_IDX = 4'h8
  } pfb_mode_t;

endpackage : pfb_pkg

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// Counts every comparison and reports a mismatch at once
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module tb_top;
  // Clock, reset and decode port
  logic ref_clk, rst, opValid, wantState;
  pfb_pkg::pfb_op_t   opKind;
  pfb_pkg::pfb_mode_t opMode;
  logic [2:0]  flagSel, bitPos, rotCount, maskCount;
  logic [7:0]  dispImm, srcReg, regWdata, regRdata;
  logic [15:0] targetAbs, indexAddr, nextPc, intPc, popPc, pcTarget;
  // Flag sources and stack side
  logic zeroFlag, carryFlag, overflowFlag, negativeFlag, receiverActiveFlag;
  logic receiverErrorFlag, rxDataAvailableFlag, txQueueFullFlag, globalInterruptEnable;
  logic [3:0]  bankSel, popFlags, popBank, regAddr;
  logic intPush, stackPop, popValid, popIntEnable, pcLoad, flushFetch, regWr, regRd;
  // Bench bookkeeping
  int fails = 0;
  int compares = 0;
  int depth = 0;                 // Expected stack depth
  logic guardOn = 1'b1;          // Guard bit as last written
  logic [31:0] lfsr = 32'h2FE13EFB;
  logic [15:0] lastTgt = 16'h0000;
  logic [24:0] stackQ[$];        // Expected entries, newest last
  pfb_pkg::pfb_op_t   kinds[5] = '{pfb_pkg::PFB_OP_REL_JUMP, pfb_pkg::PFB_OP_COND_REL,
    pfb_pkg::PFB_OP_LONG_JUMP, pfb_pkg::PFB_OP_COND_LONG, pfb_pkg::PFB_OP_ROT_MASK};
  pfb_pkg::pfb_mode_t modes[4] = '{pfb_pkg::PFB_AM_IMM, pfb_pkg::PFB_AM_REG,
    pfb_pkg::PFB_AM_ABS, pfb_pkg::PFB_AM_IDX};

  pfb_branch_unit pfb_branch_unit_inst (
    .ref_clk(ref_clk), .rst(rst), .opValid(opValid), .opKind(opKind), .opMode(opMode),
    .flagSel(flagSel), .wantState(wantState), .dispImm(dispImm), .targetAbs(targetAbs),
    .indexAddr(indexAddr), .srcReg(srcReg), .bitPos(bitPos), .rotCount(rotCount),
    .maskCount(maskCount), .nextPc(nextPc), .zeroFlag(zeroFlag), .carryFlag(carryFlag),
    .overflowFlag(overflowFlag), .negativeFlag(negativeFlag),
    .receiverActiveFlag(receiverActiveFlag), .receiverErrorFlag(receiverErrorFlag),
    .rxDataAvailableFlag(rxDataAvailableFlag), .txQueueFullFlag(txQueueFullFlag),
    .globalInterruptEnable(globalInterruptEnable), .bankSel(bankSel), .intPush(intPush),
    .intPc(intPc), .stackPop(stackPop), .popValid(popValid), .popPc(popPc),
    .popFlags(popFlags), .popIntEnable(popIntEnable), .popBank(popBank), .pcLoad(pcLoad),
    .pcTarget(pcTarget), .flushFetch(flushFetch), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata)
  );

  // Free-running 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Galois shift register, fixed seed keeps runs repeatable
  function automatic logic [31:0] nextRand();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h00000000);
    return lfsr;
  endfunction : nextRand

  // Sign-extended displacement added to the following address
  function automatic logic [15:0] relTgt(input logic [7:0] d);
    return nextPc + {{8{d[7]}}, d};
  endfunction : relTgt

  // Expected {taken, target} for one operation under current inputs
  function automatic logic [16:0] model(input pfb_pkg::pfb_op_t k, input pfb_pkg::pfb_mode_t m);
    logic [7:0] fv;
    logic [15:0] rot;
    logic [7:0] td;
    fv = {txQueueFullFlag, rxDataAvailableFlag, receiverErrorFlag, receiverActiveFlag,
          negativeFlag, overflowFlag, carryFlag, zeroFlag};
    rot = {srcReg, srcReg} >> rotCount;
    td = rot[7:0] & (8'hFF >> maskCount) & 8'hFE;
    case (k)
      pfb_pkg::PFB_OP_REL_JUMP: return m == pfb_pkg::PFB_AM_IMM ? {1'b1, relTgt(dispImm)} :
        m == pfb_pkg::PFB_AM_REG ? {1'b1, relTgt(srcReg)} : 17'h00000;
      pfb_pkg::PFB_OP_COND_REL: return {m == pfb_pkg::PFB_AM_IMM && fv[flagSel] == wantState,
        relTgt(dispImm)};
      pfb_pkg::PFB_OP_LONG_JUMP: return m == pfb_pkg::PFB_AM_IMM ? {9'h100, dispImm} :
        m == pfb_pkg::PFB_AM_REG ? {9'h100, srcReg} :
        m == pfb_pkg::PFB_AM_ABS ? {1'b1, targetAbs} : {1'b1, indexAddr};
      pfb_pkg::PFB_OP_COND_LONG: return {m == pfb_pkg::PFB_AM_ABS && srcReg[bitPos] == wantState,
        targetAbs};
      pfb_pkg::PFB_OP_ROT_MASK: return {1'b1, relTgt(td)};
      pfb_pkg::PFB_OP_CALL_REL: return {depth < 12 || !guardOn, relTgt(dispImm)};
      default: return {depth < 12 || !guardOn, targetAbs};
    endcase
  endfunction : model

  // Random operands and flags, applied on the edge
  task automatic randFields();
    logic [31:0] a, b, c;
    a = nextRand();
    b = nextRand();
    c = nextRand();
    @(posedge ref_clk);
    {zeroFlag, carryFlag, overflowFlag, negativeFlag, receiverActiveFlag, receiverErrorFlag,
     rxDataAvailableFlag, txQueueFullFlag} <= a[7:0];
    flagSel <= a[10:8];
    wantState <= a[11];
    dispImm <= a[19:12];
    srcReg <= a[27:20];
    bitPos <= a[30:28];
    globalInterruptEnable <= a[31];
    targetAbs <= b[15:0];
    indexAddr <= b[31:16];
    nextPc <= c[15:0];
    rotCount <= c[18:16];
    maskCount <= c[21:19];
    bankSel <= c[25:22];
    intPc <= {c[31:26], c[9:0]};
  endtask : randFields

  // Snapshot of what a push should save
  function automatic logic [24:0] entryNow(input logic [15:0] pc);
    return {bankSel, globalInterruptEnable, negativeFlag, overflowFlag, carryFlag, zeroFlag, pc};
  endfunction : entryNow

  // One decoded operation, redirect checked one cycle later
  task automatic doOp(input pfb_pkg::pfb_op_t k, input pfb_pkg::pfb_mode_t m);
    logic [16:0] e;
    @(posedge ref_clk);
    e = model(k, m);
    opValid <= 1'b1;
    opKind <= k;
    opMode <= m;
    if (e[16] && (k == pfb_pkg::PFB_OP_CALL_REL || k == pfb_pkg::PFB_OP_CALL_LONG)) begin
      // A taken call on a full stack replaces the top entry
      if (depth == 12) void'(stackQ.pop_back());
      else depth++;
      stackQ.push_back(entryNow(nextPc));
    end
    @(posedge ref_clk);
    opValid <= 1'b0;
    #1;
    if (e[16]) lastTgt = e[15:0];
    `CHECK("pcLoad", e[16], pcLoad)
    `CHECK("flushFetch", e[16], flushFetch)
    `CHECK("pcTarget", lastTgt, pcTarget)
  endtask : doOp

  // Register port cycles
  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    `CHECK("regRdata", exp, regRdata)
  endtask : regRead

  // Pop one entry and compare with the newest expected one
  task automatic popCheck();
    logic [24:0] ent;
    @(posedge ref_clk);
    stackPop <= 1'b1;
    @(posedge ref_clk);
    stackPop <= 1'b0;
    #1;
    `CHECK("popValid", stackQ.size() > 0, popValid)
    if (stackQ.size() > 0) begin
      ent = stackQ.pop_back();
      `CHECK("popEntry", ent, {popBank, popIntEnable, popFlags, popPc})
      depth--;
    end
  endtask : popCheck

  // Verdict and end of run
  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  // Hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    complete_run();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {opValid, wantState, intPush, stackPop, regWr, regRd} = 6'h00;
    opKind = pfb_pkg::PFB_OP_REL_JUMP;
    opMode = pfb_pkg::PFB_AM_IMM;
    {flagSel, bitPos, rotCount, maskCount, dispImm, srcReg, regWdata, regAddr} = 40'h0;
    {targetAbs, indexAddr, nextPc, intPc, bankSel} = 68'h0;
    {zeroFlag, carryFlag, overflowFlag, negativeFlag, receiverActiveFlag, receiverErrorFlag,
     rxDataAvailableFlag, txQueueFullFlag, globalInterruptEnable} = 9'h000;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    `CHECK("pcLoad", 1'b0, pcLoad)
    regRead(4'h0, 8'h01);
    regRead(4'h1, 8'h20);
    // Every selector code with both wanted states, extreme displacements
    for (int i = 0; i < 16; i++) begin
      randFields();
      flagSel <= i[2:0];
      wantState <= i[3];
      dispImm <= i[0] ? 8'h80 : 8'h7F;
      doOp(pfb_pkg::PFB_OP_COND_REL, pfb_pkg::PFB_AM_IMM);
    end
    // Random mix of jump kinds and modes, illegal modes among them
    for (int i = 0; i < 80; i++) begin
      randFields();
      doOp(kinds[i % 5], i % 5 == 4 ? pfb_pkg::PFB_AM_REG : modes[(i / 5) % 4]);
    end
    regRead(4'h2, lastTgt[7:0]);
    regRead(4'h3, lastTgt[15:8]);
    regWrite(4'hF, 8'hFF);
    regRead(4'hF, 8'h00);
    regRead(4'h0, 8'h01);
    // Fill the stack with calls and one interrupt push
    for (int i = 0; i < 12; i++) begin
      randFields();
      if (i == 5) begin
        @(posedge ref_clk);
        intPush <= 1'b1;
        stackQ.push_back(entryNow(intPc));
        depth++;
        @(posedge ref_clk);
        intPush <= 1'b0;
      end
      else doOp(i[0] ? pfb_pkg::PFB_OP_CALL_LONG : pfb_pkg::PFB_OP_CALL_REL,
        i[0] ? pfb_pkg::PFB_AM_ABS : pfb_pkg::PFB_AM_IMM);
    end
    regRead(4'h1, 8'h1C);
    randFields();
    doOp(pfb_pkg::PFB_OP_CALL_LONG, pfb_pkg::PFB_AM_ABS);
    regRead(4'h1, 8'h5C);
    regWrite(4'h1, 8'hC0);
    regRead(4'h1, 8'h1C);
    // Guard off: a call on a full stack is taken and replaces the top
    regWrite(4'h0, 8'h00);
    guardOn = 1'b0;
    regRead(4'h0, 8'h00);
    randFields();
    doOp(pfb_pkg::PFB_OP_CALL_LONG, pfb_pkg::PFB_AM_ABS);
    regRead(4'h1, 8'h5C);
    regWrite(4'h1, 8'h40);
    regWrite(4'h0, 8'h01);
    guardOn = 1'b1;
    // Drain in reverse order, then one pop too many
    for (int i = 0; i < 13; i++) popCheck();
    regRead(4'h1, 8'hA0);
    // Stack clear wipes pending entries
    randFields();
    doOp(pfb_pkg::PFB_OP_CALL_REL, pfb_pkg::PFB_AM_IMM);
    regWrite(4'h0, 8'h03);
    stackQ.delete();
    depth = 0;
    regRead(4'h1, 8'hA0);
    regRead(4'h0, 8'h01);
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
